// file: bench/lcis_source_model.sv
// Purpose: stand-in for the peripherals and pins that feed the source selectors
// Assumes: every source is synchronous to clk_sys
// Notes:   the bench sets each level through pattern; bit order follows the bench map
`timescale 1ns/1ns
module lcis_source_model
(
   input  wire logic        clk_sys,
   input  wire logic [23:0] pattern,
   output logic      [23:0] lines
);
   // sources launch from clk_sys so the selector never samples a moving level
   always_ff @(posedge clk_sys)
   begin
      lines <= pattern;
   end
endmodule : lcis_source_model

// file: bench/lcis_top_bench.sv
// Purpose: self-checking bench for the logic cell input selector
// Assumes: the bench wires the first cell's own peripherals and peer output
// Notes:   the second cell differs only in wiring, so one instance covers both
`timescale 1ns/1ns
`include "lcis_regs.svh"
module lcis_top_bench;
   import lcis_pkg::*;
   logic         clk_sys = 1'b0;
   logic         rst = 1'b1;
   logic         hsel = 1'b0;
   lcis_word_t   haddr = '0;
   lcis_htrans_t htrans = LCIS_IDLE;
   logic         hwrite = 1'b0;
   lcis_word_t   hwdata = '0;
   logic         hreadyout;
   logic         hresp;
   lcis_word_t   hrdata;
   logic [23:0]  pattern = '0;
   logic [23:0]  lines;
   lcis_nib_t    gate_out;
   lcis_nib_t    exp4;
   logic         v;
   int           idx;
   int           mismatches = 0;
   int           checked = 0;
   // source index per selector and code; 24 marks a reserved code
   localparam int SRC_MAP [4][8] = '{'{0, 2, 3, 4, 5, 6, 7, 8},
      '{1, 23, 16, 19, 15, 24, 9, 24}, '{0, 22, 17, 21, 18, 12, 10, 11},
      '{1, 23, 13, 20, 24, 14, 9, 11}};

   always #25 clk_sys = ~clk_sys;

   lcis_source_model lcis_source_model_i (.clk_sys(clk_sys), .pattern(pattern), .lines(lines));

   lcis_top lcis_top_i (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .cell_input_pin_a(lines[0]), .cell_input_pin_b(lines[1]),
      .system_clock_source(lines[2]), .secondary_osc_clock(lines[3]),
      .low_power_rc_clock(lines[4]), .reference_clock_out(lines[5]),
      .multi_compare_out_a(lines[6]), .multi_compare_out_b(lines[7]),
      .multi_compare_out_c(lines[8]), .multi_capture_match(lines[9]),
      .second_capture_match(lines[10]), .third_capture_match(lines[11]),
      .second_single_compare_out(lines[12]), .third_single_compare_out(lines[13]),
      .calendar_event_source(lines[14]), .adc_conv_done(lines[15]),
      .comparator_one_out(lines[16]), .comparator_two_out(lines[17]),
      .uart_rx_in(lines[18]), .uart_tx_out(lines[19]), .spi_data_in(lines[20]),
      .spi_data_out(lines[21]), .own_cell_out(lines[22]), .peer_cell_out(lines[23]),
      .gate_out(gate_out));

   task automatic check(input lcis_word_t seen, input lcis_word_t exp);
      checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // entered right after a rising edge; returns at the edge that ends the data phase
   task automatic bus_cycle(input lcis_ofs_t ofs, input logic wr, input lcis_word_t wd,
      output lcis_word_t rdv);
      hsel <= 1'b1;
      haddr <= {24'h0, ofs};
      hwrite <= wr;
      htrans <= LCIS_NONSEQ;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= LCIS_IDLE;
      hwdata <= wd;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      rdv = hrdata;
   endtask : bus_cycle

   task automatic wr_reg(input lcis_ofs_t ofs, input lcis_word_t wd);
      lcis_word_t dummy;
      bus_cycle(ofs, 1'b1, wd, dummy);
   endtask : wr_reg

   task automatic rd_chk(input lcis_ofs_t ofs, input lcis_word_t exp);
      lcis_word_t rdv;
      bus_cycle(ofs, 1'b0, '0, rdv);
      check(rdv, exp);
      check({31'h0, hresp}, `LCIS_ZERO_WORD);
   endtask : rd_chk

   // one edge through the source model, one through the gate register, one to sample
   task automatic settle();
      repeat (3) @(posedge clk_sys);
   endtask : settle

   task automatic end_of_test();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : end_of_test

   initial
   begin
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      rd_chk(`LCIS_SEL_OFS, `LCIS_SEL_RST);
      rd_chk(`LCIS_GLS_OFS, `LCIS_GLS_RST);
      rd_chk(`LCIS_POL_OFS, `LCIS_ZERO_WORD);
      wr_reg(`LCIS_SEL_OFS, 32'hFFFF_FFFF);
      rd_chk(`LCIS_SEL_OFS, 32'h0000_7777);
      wr_reg(`LCIS_GLS_OFS, 32'hFFFF_FFFF);
      rd_chk(`LCIS_GLS_OFS, 32'hFFFF_FFFF);
      rd_chk(8'h10, `LCIS_ZERO_WORD);
      $display("test register access done");
      for (int d = 0; d < 4; d++)
         for (int c = 0; c < 8; c++)
         begin
            wr_reg(`LCIS_SEL_OFS, 32'(c) << (4 * d));
            wr_reg(`LCIS_GLS_OFS, 32'h1 << (2 * d + 1));
            idx = SRC_MAP[d][c];
            for (int p = 0; p < 2; p++)
            begin
               // one-hot then all-but-one: only the mapped source can make gate 1 follow
               pattern <= (idx < 24) ? (24'h1 << idx) ^ {24{p[0]}} : {24{p[0]}};
               settle();
               check({28'h0, gate_out}, {31'h0, (idx < 24) && (p == 0)});
            end
         end
      $display("test source selectors done");
      wr_reg(`LCIS_SEL_OFS, `LCIS_ZERO_WORD);
      // pin a high, pin b low, so the four sources read 1, 0, 1, 0
      pattern <= 24'h1;
      for (int b = 0; b < 32; b++)
      begin
         wr_reg(`LCIS_GLS_OFS, 32'h1 << b);
         settle();
         v = ((b % 2) == 1) == (((b / 2) % 2) == 0);
         exp4 = lcis_nib_t'(v) << (b / 8);
         check({28'h0, gate_out}, {28'h0, exp4});
      end
      $display("test enable matrix done");
      wr_reg(`LCIS_GLS_OFS, 32'h0000_000A);
      settle();
      check({28'h0, gate_out}, 32'h0000_0001);
      rd_chk(`LCIS_STAT_OFS, 32'h0000_0001);
      wr_reg(`LCIS_POL_OFS, 32'hFFFF_FFFF);
      settle();
      check({28'h0, gate_out}, 32'h0000_000E);
      rd_chk(`LCIS_POL_OFS, 32'h0000_000F);
      wr_reg(`LCIS_STAT_OFS, `LCIS_ZERO_WORD);
      rd_chk(`LCIS_STAT_OFS, 32'h0000_000E);
      wr_reg(`LCIS_GLS_OFS, `LCIS_ZERO_WORD);
      settle();
      check({28'h0, gate_out}, 32'h0000_000F);
      $display("test gate or and polarity done");
      rst <= 1'b1;
      @(posedge clk_sys);
      rst <= 1'b0;
      rd_chk(`LCIS_GLS_OFS, `LCIS_GLS_RST);
      settle();
      check({28'h0, gate_out}, `LCIS_ZERO_WORD);
      $display("test mid-run reset done");
      end_of_test();
   end

   // the tests need a few hundred cycles; this allows about forty thousand
   initial
   begin
      #2000000;
      mismatches++;
      end_of_test();
   end
endmodule : lcis_top_bench

// file: hdl/lcis_gate_if.sv
// Purpose: carries selected sources, enables and polarity to the gate matrix
// Assumes: one driver per signal
// Notes:   ctl is the register side, mat the matrix side
`timescale 1ns/1ns
interface lcis_gate_if;
   import lcis_pkg::*;
   lcis_nib_t  src;
   lcis_word_t enable;
   lcis_nib_t  invert;
   lcis_nib_t  gate;
   modport ctl (output src, output enable, output invert, input gate);
   modport mat (input src, input enable, input invert, output gate);
endinterface : lcis_gate_if

// file: hdl/lcis_gate_matrix.sv
// Purpose: four gates, each an OR of enabled true and inverted sources
// Assumes: enable word laid out one byte per gate, two bits per source
// Notes:   purely combinational; the top registers the result
`timescale 1ns/1ns
`include "lcis_regs.svh"
module lcis_gate_matrix
#(
   parameter int NGATES = 4,
   parameter int NSRC   = 4
)
(
   lcis_gate_if.mat gif
);
   import lcis_pkg::*;

   function automatic logic gate_term
   (
      input lcis_word_t en,
      input lcis_nib_t  src,
      input int         g
   );
      logic acc;
      int   base;
      acc = 1'h0;
      for (int d = 0; d < NSRC; d++)
      begin
         base = `LCIS_GATE_STRIDE * g + `LCIS_SRC_STRIDE * d;
         acc  = acc | (en[base + 1] & src[d]);
         acc  = acc | (en[base] & ~src[d]);
      end
      return acc;
   endfunction : gate_term

   always_comb
   begin
      for (int g = 0; g < NGATES; g++)
      begin
         // no enable set leaves the OR at zero before polarity
         gif.gate[g] = gate_term(gif.enable, gif.src, g) ^ gif.invert[g];
      end
   end
endmodule : lcis_gate_matrix

// file: hdl/lcis_pkg.sv
// Purpose: shared types of the logic cell input selector
// Assumes: nothing beyond the header of offsets
// Notes:   htrans values follow the public bus encoding
package lcis_pkg;
   typedef logic [31:0] lcis_word_t;
   typedef logic [3:0]  lcis_nib_t;
   typedef logic [2:0]  lcis_code_t;
   typedef logic [7:0]  lcis_ofs_t;
   typedef enum logic [1:0]
   {
      LCIS_IDLE   = 2'h0,
      LCIS_BUSY   = 2'h1,
      LCIS_NONSEQ = 2'h2,
      LCIS_SEQ    = 2'h3
   } lcis_htrans_t;
endpackage : lcis_pkg

// file: hdl/lcis_regs.svh
// Purpose: register offsets, masks, field positions and codes of the input selector
// Assumes: word-aligned registers decoded on the low address byte
// Notes:   definitions only
`ifndef LCIS_REGS_SVH
`define LCIS_REGS_SVH

`define LCIS_SEL_OFS      8'h00
`define LCIS_GLS_OFS      8'h04
`define LCIS_POL_OFS      8'h08
`define LCIS_STAT_OFS     8'h0C

`define LCIS_SEL_MASK     32'h0000_7777
`define LCIS_SEL_RST      32'h0000_0000
`define LCIS_GLS_RST      32'h0000_0000
`define LCIS_POL_MASK     32'h0000_000F
`define LCIS_POL_RST      4'h0
`define LCIS_ZERO_WORD    32'h0000_0000

`define LCIS_SEL1_LSB     0
`define LCIS_SEL2_LSB     4
`define LCIS_SEL3_LSB     8
`define LCIS_SEL4_LSB     12
`define LCIS_SEL_RSVD     32'h0000_0888

`define LCIS_GATE_STRIDE  8
`define LCIS_SRC_STRIDE   2

`define LCIS_CODE_0       3'h0
`define LCIS_CODE_1       3'h1
`define LCIS_CODE_3       3'h3
`define LCIS_CODE_4       3'h4
`define LCIS_CODE_5       3'h5
`define LCIS_CODE_7       3'h7

`define LCIS_G1_D1_TRUE   32'h0000_0002
`define LCIS_G1_D1_NEG    32'h0000_0001
`define LCIS_G4_D3_TRUE   32'h2000_0000
`define LCIS_G1_BYTE      7:0
`define LCIS_G1_D12_TRUE  8'h0A

`endif

// file: hdl/lcis_top.sv
// Purpose: input selection front end of one configurable logic cell, AHB-Lite registers
// Assumes: source inputs synchronous to clk_sys; single word transfers only
// Notes:   both cells use this module; wiring of uart/spi/peer ports tells them apart
//
// How it works
// - second cell mux4: sdi, compares, calendar, pin B
// - select bits 11, 7, 3 read zero
// - first cell mux3: compares, uart rx, sdo, pin A
// - second cell mux3 uses its own peripherals
// - first cell mux2: match, adc, uart tx, pin B
// - second cell mux2 uses uart2, first cell out
// - mux1 picks multi outputs, clocks or pin A
// - true enable bit feeds source to gate
// - negated enable bit feeds inverted source
// - enable register: byte per gate, reset zero
// - source 4 pair is top of byte
// - first cell mux4: sdi1, compares, peer out
// - per-gate polarity inverts gate output
//
// The address map and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`include "lcis_regs.svh"
module lcis_top
(
   input  wire  logic               clk_sys,
   input  wire  logic               rst,
   input  wire  logic               hsel,
   input  wire  lcis_pkg::lcis_word_t haddr,
   input  wire  logic [1:0]         htrans,
   input  wire  logic               hwrite,
   input  wire  logic [2:0]         hsize,
   input  wire  lcis_pkg::lcis_word_t hwdata,
   input  wire  logic               hready,
   output logic                     hreadyout,
   output logic                     hresp,
   output lcis_pkg::lcis_word_t     hrdata,
   input  wire  logic               cell_input_pin_a,
   input  wire  logic               cell_input_pin_b,
   input  wire  logic               system_clock_source,
   input  wire  logic               secondary_osc_clock,
   input  wire  logic               low_power_rc_clock,
   input  wire  logic               reference_clock_out,
   input  wire  logic               multi_compare_out_a,
   input  wire  logic               multi_compare_out_b,
   input  wire  logic               multi_compare_out_c,
   input  wire  logic               multi_capture_match,
   input  wire  logic               second_capture_match,
   input  wire  logic               third_capture_match,
   input  wire  logic               second_single_compare_out,
   input  wire  logic               third_single_compare_out,
   input  wire  logic               calendar_event_source,
   input  wire  logic               adc_conv_done,
   input  wire  logic               comparator_one_out,
   input  wire  logic               comparator_two_out,
   input  wire  logic               uart_rx_in,
   input  wire  logic               uart_tx_out,
   input  wire  logic               spi_data_in,
   input  wire  logic               spi_data_out,
   input  wire  logic               own_cell_out,
   input  wire  logic               peer_cell_out,
   output lcis_pkg::lcis_nib_t      gate_out
);
   import lcis_pkg::*;

   lcis_gate_if gif ();

   lcis_word_t sel_r;
   lcis_word_t sel_nxt;
   lcis_word_t gls_r;
   lcis_word_t gls_nxt;
   lcis_nib_t  pol_r;
   lcis_nib_t  pol_nxt;
   lcis_nib_t  gate_out_r;
   lcis_word_t hrdata_r;
   logic       wr_pend_r;
   lcis_ofs_t  wr_ofs_r;
   logic       take;
   logic       rd_take;
   lcis_code_t code1;
   lcis_code_t code2;
   lcis_code_t code3;
   lcis_code_t code4;

   function automatic lcis_code_t field
   (
      input lcis_word_t word,
      input int         lsb
   );
      return word[lsb +: 3];
   endfunction : field

   // one candidate per code; reserved slots are tied low by the caller
   function automatic logic src_pick
   (
      input lcis_code_t code,
      input logic [7:0] opts
   );
      return opts[code];
   endfunction : src_pick

   function automatic lcis_word_t read_word
   (
      input lcis_ofs_t  ofs,
      input lcis_word_t sel,
      input lcis_word_t gls,
      input lcis_nib_t  pol,
      input lcis_nib_t  gates
   );
      lcis_word_t w;
      w = `LCIS_ZERO_WORD;
      case (ofs)
         `LCIS_SEL_OFS  : w = sel & `LCIS_SEL_MASK;
         `LCIS_GLS_OFS  : w = gls;
         `LCIS_POL_OFS  : w = {28'h0, pol};
         `LCIS_STAT_OFS : w = {28'h0, gates};
         default        : w = `LCIS_ZERO_WORD;
      endcase
      return w;
   endfunction : read_word

   assign take      = hsel & hready & ((htrans == LCIS_NONSEQ) | (htrans == LCIS_SEQ));
   assign rd_take   = take & ~hwrite;
   assign hreadyout = 1'h1;
   assign hresp     = 1'h0;
   assign hrdata    = hrdata_r;
   assign gate_out  = gate_out_r;

   // bus address phase: remember a pending write for its data phase
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         wr_pend_r <= 1'h0;
         wr_ofs_r  <= `LCIS_SEL_OFS;
      end
      else if (take)
      begin
         wr_pend_r <= hwrite;
         wr_ofs_r  <= haddr[7:0];
      end
      else if (hready)
      begin
         wr_pend_r <= 1'h0;
      end
   end

   always_comb
   begin
      sel_nxt = sel_r;
      gls_nxt = gls_r;
      pol_nxt = pol_r;
      if (wr_pend_r)
      begin
         case (wr_ofs_r)
            `LCIS_SEL_OFS : sel_nxt = hwdata & `LCIS_SEL_MASK;
            `LCIS_GLS_OFS : gls_nxt = hwdata;
            `LCIS_POL_OFS : pol_nxt = hwdata[3:0];
            default       : sel_nxt = sel_r;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         sel_r <= `LCIS_SEL_RST;
         gls_r <= `LCIS_GLS_RST;
         pol_r <= `LCIS_POL_RST;
      end
      else
      begin
         sel_r <= sel_nxt;
         gls_r <= gls_nxt;
         pol_r <= pol_nxt;
      end
   end

   // read data built from next values so a write right before a read is seen
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         hrdata_r <= `LCIS_ZERO_WORD;
      end
      else if (rd_take)
      begin
         hrdata_r <= read_word(haddr[7:0], sel_nxt, gls_nxt, pol_nxt, gate_out_r);
      end
   end

   assign code1 = field(sel_r, `LCIS_SEL1_LSB);
   assign code2 = field(sel_r, `LCIS_SEL2_LSB);
   assign code3 = field(sel_r, `LCIS_SEL3_LSB);
   assign code4 = field(sel_r, `LCIS_SEL4_LSB);

   // clocks are sampled by clk_sys here, so sources near its rate alias
   assign gif.src[0] = src_pick(code1, {multi_compare_out_c, multi_compare_out_b,
      multi_compare_out_a, reference_clock_out, low_power_rc_clock,
      secondary_osc_clock, system_clock_source, cell_input_pin_a});
   assign gif.src[1] = src_pick(code2, {1'h0, multi_capture_match, 1'h0,
      adc_conv_done, uart_tx_out, comparator_one_out, peer_cell_out,
      cell_input_pin_b});
   assign gif.src[2] = src_pick(code3, {third_capture_match, second_capture_match,
      second_single_compare_out, uart_rx_in, spi_data_out, comparator_two_out,
      own_cell_out, cell_input_pin_a});
   assign gif.src[3] = src_pick(code4, {third_capture_match, multi_capture_match,
      calendar_event_source, 1'h0, spi_data_in, third_single_compare_out,
      peer_cell_out, cell_input_pin_b});
   assign gif.enable = gls_r;
   assign gif.invert = pol_r;

   lcis_gate_matrix #(.NGATES(4), .NSRC(4)) u_matrix
   (
      .gif (gif.mat)
   );

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         gate_out_r <= `LCIS_POL_RST;
      end
      else
      begin
         gate_out_r <= gif.gate;
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   AST_SEL_RSVD_ZERO: assert property
      (wr_pend_r && wr_ofs_r == `LCIS_SEL_OFS
       |=> (sel_r & `LCIS_SEL_RSVD) == `LCIS_ZERO_WORD)
      else $error("reserved select bits stored a one");

   AST_MUX4_SDI: assert property
      (code4 == `LCIS_CODE_3 |-> gif.src[3] == spi_data_in)
      else $error("mux4 code 3 not the spi data input");

   AST_MUX4_RSVD: assert property
      (code4 == `LCIS_CODE_4 |-> !gif.src[3])
      else $error("mux4 reserved code not zero");

   AST_MUX3_RX: assert property
      (code3 == `LCIS_CODE_4 |-> gif.src[2] == uart_rx_in)
      else $error("mux3 code 4 not the uart receive input");

   AST_MUX2_RSVD: assert property
      ((code2 == `LCIS_CODE_7 || code2 == `LCIS_CODE_5) |-> !gif.src[1])
      else $error("mux2 reserved code not zero");

   AST_MUX1_SYSCLK: assert property
      (code1 == `LCIS_CODE_1 |-> gif.src[0] == system_clock_source)
      else $error("mux1 code 1 not the system clock");

   AST_MUX1_PIN: assert property
      (code1 == `LCIS_CODE_0 |-> gif.src[0] == cell_input_pin_a)
      else $error("mux1 code 0 not input pin a");

   AST_MUX2_PEER: assert property
      (code2 == `LCIS_CODE_1 |-> gif.src[1] == peer_cell_out)
      else $error("mux2 code 1 not the peer cell output");

   AST_MUX3_OWN: assert property
      (code3 == `LCIS_CODE_1 |-> gif.src[2] == own_cell_out)
      else $error("mux3 code 1 not the own cell output");

   AST_MUX4_PEER: assert property
      (code4 == `LCIS_CODE_1 |-> gif.src[3] == peer_cell_out)
      else $error("mux4 code 1 not the peer cell output");

   AST_GATE1_TRUE: assert property
      (gls_r == `LCIS_G1_D1_TRUE && !pol_r[0] |=> gate_out_r[0] == $past(gif.src[0]))
      else $error("gate 1 true path wrong");

   AST_GATE1_NEG: assert property
      (gls_r == `LCIS_G1_D1_NEG && !pol_r[0] |=> gate_out_r[0] == !$past(gif.src[0]))
      else $error("gate 1 inverted path wrong");

   AST_GATE_ZERO: assert property
      (gls_r[`LCIS_G1_BYTE] == 8'h00 && !pol_r[0] |=> !gate_out_r[0])
      else $error("gate 1 not zero with no enables");

   AST_GATE_OR: assert property
      (gls_r[`LCIS_G1_BYTE] == `LCIS_G1_D12_TRUE && !pol_r[0]
       |=> gate_out_r[0] == ($past(gif.src[0]) || $past(gif.src[1])))
      else $error("gate 1 not the or of its true terms");

   AST_GATE_POL: assert property
      (gls_r[`LCIS_G1_BYTE] == 8'h00 && pol_r[0] |=> gate_out_r[0])
      else $error("gate 1 polarity not applied");

   AST_GLS_WRITE: assert property
      (wr_pend_r && wr_ofs_r == `LCIS_GLS_OFS |=> gls_r == $past(hwdata))
      else $error("enable register write lost");

   AST_GATE4_SRC3: assert property
      (gls_r == `LCIS_G4_D3_TRUE && !pol_r[3] |=> gate_out_r[3] == $past(gif.src[2]))
      else $error("gate 4 source 3 bit pair misplaced");

   AST_READ_SEL: assert property
      (rd_take && haddr[7:0] == `LCIS_SEL_OFS
       |=> (hrdata_r & `LCIS_SEL_RSVD) == `LCIS_ZERO_WORD)
      else $error("select readback shows reserved bits");
endmodule : lcis_top
